//--- irl_map.vh
// register indices, field positions, reset values and rate constants
// for the ingress rate limiter; included by irl_limiter.v only
`ifndef IRL_MAP_VH
`define IRL_MAP_VH
// register indices (byte address is four times the index)
`define IRL_IDX_CFG       8'h03
`define IRL_IDX_PRIO0     8'h10
`define IRL_IDX_PRIO7     8'h17
`define IRL_IDX_MAC       8'h20
`define IRL_IDX_STAT      8'h21
// port ingress limit config fields
`define IRL_CFG_PORT      6
`define IRL_CFG_PPS       5
`define IRL_CFG_FC        4
`define IRL_CFG_MODE_HI   3
`define IRL_CFG_MODE_LO   2
`define IRL_CFG_IFG       1
`define IRL_CFG_PRE       0
`define IRL_CFG_RST       8'h00
`define IRL_CODE_RST      7'h00
// limit mode encodings
`define IRL_MODE_ALL      2'b00
`define IRL_MODE_BMF      2'b01
`define IRL_MODE_BM       2'b10
`define IRL_MODE_B        2'b11
// port mac config fields
`define IRL_MAC_SPD1000   6
`define IRL_MAC_SPD100    4
`define IRL_MAC_RXFC      3
`define IRL_MAC_RST       8'h10
// status fields
`define IRL_STAT_FC       0
`define IRL_STAT_OVR      1
// speed encodings
`define IRL_SPD_10        2'd0
`define IRL_SPD_100       2'd1
`define IRL_SPD_1000      2'd2
// per-frame overhead bytes
`define IRL_IFG_BYTES     16'd12
`define IRL_PRE_BYTES     16'd8
// rate code boundaries
`define IRL_CODE_LOW_MAX  7'd10
`define IRL_CODE_MID_MAX  7'd100
`define IRL_CODE_TAB_MAX  7'd115
`define IRL_TAB_BIG_MAX   32'd3
// rate units, bit rates held as bytes per second
`define IRL_MBPS_BYTES    32'd125000
`define IRL_KBPS_BYTES    32'd125
`define IRL_PPS_UNIT      32'd1920
`define IRL_PPS_UNIT_G    32'd19200
`define IRL_TAB_KBPS      32'd64
`define IRL_TAB_KBPS_G    32'd640
`define IRL_TAB_PPS1      32'd64
`define IRL_TAB_PPS       32'd128
`define IRL_TAB_G_MUL     32'd10
`define IRL_LINE_10       32'd10
`define IRL_LINE_100      32'd100
`define IRL_LINE_1000     32'd1000
`define IRL_FULL_PPS_10   32'd19200
`define IRL_FULL_PPS_100  32'd192000
`define IRL_FULL_PPS_G    32'd1920000
// measurement window: 1000 ms at 25000 kHz
`define IRL_WINDOW_MS     1000
`define IRL_CLK_KHZ       25000
`endif

//--- irl_limiter.v
// ingress rate limiter for one switch port, wishbone classic slave
// assumes frame descriptors arrive on the core clock, one per pulse
`timescale 1ns/1ps
`include "irl_map.vh"

// Overview of operation
// - port bit one: one limit for the port; zero: one per priority
// - packet mode bit one counts frames, zero counts bytes
// - flow-control bit set: assert flow control while rate exceeded
// - rate flow control only acts when port flow control enabled
// - mode field picks frames counted: all, b/m/flood, b/m, bcast
// - gap bit adds 12 bytes per frame to the count
// - preamble bit adds 8 bytes per frame to the count
// - preamble option ignored in packet mode
// - each priority has 7-bit code, top bit reads zero
// - new priority codes commit only when priority 7 written
// - rate code interpreted by current port speed
// - codes 1-10: 1 Mbps or 1.92k/19.2k packets per code
// - codes 11-100: speed-dependent bit and packet limits
// - speed from speed bits: 1000, else 100 or 10
// - receive flow-control enable gates pause on congestion
module irl_limiter #(
	parameter WINDOW_CYC = `IRL_WINDOW_MS * `IRL_CLK_KHZ,
	parameter LEN_W      = 16
) (
	// clock and reset
	input  wire             clock_in,
	input  wire             srst_in,
	// wishbone classic slave
	input  wire             wb_cyc_in,
	input  wire             wb_stb_in,
	input  wire             wb_we_in,
	input  wire [9:0]       wb_adr_in,
	input  wire [3:0]       wb_sel_in,
	input  wire [31:0]      wb_dat_in,
	output reg  [31:0]      wb_dat_out,
	output wire             wb_ack_out,
	// received frame descriptor
	input  wire             frame_valid_in,
	input  wire [LEN_W-1:0] frame_len_in,
	input  wire [2:0]       frame_prio_in,
	input  wire             frame_bcast_in,
	input  wire             frame_mcast_in,
	input  wire             frame_flood_in,
	// limiter results
	output reg              frame_drop_out,
	output reg              flow_ctrl_out
);

	// registers
	reg  [7:0]  cfg_r;
	reg  [7:0]  mac_r;
	reg  [6:0]  code_wr_r [0:7];
	reg  [6:0]  code_act_r [0:7];
	reg  [31:0] used_r [0:7];
	reg         ack_r;
	reg         ovr_r;
	reg  [31:0] win_cnt_r;
	integer     i;

	// bus decode
	wire [7:0]  idx     = wb_adr_in[9:2];
	wire        req     = wb_cyc_in & wb_stb_in & ~ack_r;
	wire        wr      = req & wb_we_in & wb_sel_in[0];
	wire        is_prio = (idx[7:3] == `IRL_IDX_PRIO0 >> 3);

	// speed selection
	wire        spd1000 = mac_r[`IRL_MAC_SPD1000];
	wire [1:0]  speed   = spd1000 ? `IRL_SPD_1000 :
		(mac_r[`IRL_MAC_SPD100] ? `IRL_SPD_100 : `IRL_SPD_10);
	wire        packet_rate_mode     = cfg_r[`IRL_CFG_PPS];

	// rate code to per-window allowance (bytes/s or frames/s)
	function [31:0] limit_f;
		input [6:0] c;
		input [1:0] spd;
		input       pkt;
		reg   [31:0] cw;
		reg   [31:0] k;
		reg   [31:0] line;
		reg   [31:0] full_p;
		reg   [31:0] kb;
		reg   [31:0] pp;
		begin
			cw = {25'd0, c};
			k = cw - {25'd0, `IRL_CODE_MID_MAX};
			line = (spd == `IRL_SPD_1000) ? `IRL_LINE_1000 :
				((spd == `IRL_SPD_100) ? `IRL_LINE_100 : `IRL_LINE_10);
			full_p = (spd == `IRL_SPD_1000) ? `IRL_FULL_PPS_G :
				((spd == `IRL_SPD_100) ? `IRL_FULL_PPS_100 :
				`IRL_FULL_PPS_10);
			// fixed low-rate table
			kb = (spd == `IRL_SPD_1000 ||
				(spd == `IRL_SPD_100 && k <= `IRL_TAB_BIG_MAX)) ?
				`IRL_TAB_KBPS_G * k : `IRL_TAB_KBPS * k;
			// 64 for the first table code, then steps of 128
			pp = (k == 32'd1) ? `IRL_TAB_PPS1 :
				`IRL_TAB_PPS * (k - 32'd1);
			if (spd == `IRL_SPD_1000) begin
				pp = pp * `IRL_TAB_G_MUL;
			end
			if (c == 7'd0 || c > `IRL_CODE_TAB_MAX) begin
				// no reduction; undefined codes also run at line rate
				limit_f = pkt ? full_p : line * `IRL_MBPS_BYTES;
			end else if (c <= `IRL_CODE_LOW_MAX) begin
				limit_f = pkt ? cw * ((spd == `IRL_SPD_1000) ?
					`IRL_PPS_UNIT_G : `IRL_PPS_UNIT) :
					cw * `IRL_MBPS_BYTES;
			end else if (c <= `IRL_CODE_MID_MAX) begin
				if (spd == `IRL_SPD_10) begin
					// packet limit undefined here: full frame rate
					limit_f = pkt ? full_p :
						`IRL_LINE_10 * `IRL_MBPS_BYTES;
				end else if (spd == `IRL_SPD_100) begin
					limit_f = pkt ? cw * `IRL_PPS_UNIT :
						cw * `IRL_MBPS_BYTES;
				end else begin
					limit_f = pkt ? cw * `IRL_PPS_UNIT_G :
						cw * `IRL_LINE_10 * `IRL_MBPS_BYTES;
				end
			end else begin
				limit_f = pkt ? pp : kb * `IRL_KBPS_BYTES;
			end
		end
	endfunction

	// frame classification
	wire [1:0]  mode = cfg_r[`IRL_CFG_MODE_HI:`IRL_CFG_MODE_LO];
	reg         counted;
	always @* begin
		case (mode)
			`IRL_MODE_ALL: counted = 1'b1;
			`IRL_MODE_BMF: counted = frame_bcast_in | frame_mcast_in |
				frame_flood_in;
			`IRL_MODE_BM:  counted = frame_bcast_in | frame_mcast_in;
			`IRL_MODE_B:   counted = frame_bcast_in;
			default:       counted = 1'b1;
		endcase
	end

	// bucket choice and frame cost
	wire [2:0]  bkt = cfg_r[`IRL_CFG_PORT] ? 3'd0 : frame_prio_in;
	wire [15:0] len16 = frame_len_in[15:0];
	wire [15:0] ifg_add = cfg_r[`IRL_CFG_IFG] ? `IRL_IFG_BYTES :
		16'd0;
	wire [15:0] pre_add = (cfg_r[`IRL_CFG_PRE] & ~packet_rate_mode) ? `IRL_PRE_BYTES :
		16'd0;
	wire [31:0] cost = packet_rate_mode ? 32'd1 :
		{16'd0, len16} + {16'd0, ifg_add} + {16'd0, pre_add};
	wire [31:0] limit = limit_f(code_act_r[bkt], speed, packet_rate_mode);
	wire [32:0] sum = {1'b0, used_r[bkt]} + {1'b0, cost};
	wire        exceed = frame_valid_in & counted & (sum > {1'b0, limit});
	wire        win_end = (win_cnt_r == WINDOW_CYC - 1);

	// measurement window timer
	always @(posedge clock_in) begin
		if (srst_in || win_end) begin
			win_cnt_r <= 32'd0;
		end else begin
			win_cnt_r <= win_cnt_r + 32'd1;
		end
	end

	// per-bucket usage within the window
	always @(posedge clock_in) begin
		if (srst_in || win_end) begin
			for (i = 0; i < 8; i = i + 1) begin
				used_r[i] <= 32'd0;
			end
		end else if (frame_valid_in && counted && !exceed) begin
			used_r[bkt] <= sum[31:0];
		end
	end

	// overrun flag, drop pulse and flow control
	always @(posedge clock_in) begin
		if (srst_in) begin
			ovr_r <= 1'b0;
			frame_drop_out <= 1'b0;
			flow_ctrl_out <= 1'b0;
		end else begin
			ovr_r <= (ovr_r & ~win_end) | exceed; // set wins over clear
			frame_drop_out <= exceed;
			flow_ctrl_out <= ((ovr_r & ~win_end) | exceed) &
				cfg_r[`IRL_CFG_FC] &
				mac_r[`IRL_MAC_RXFC];
		end
	end

	// register writes
	always @(posedge clock_in) begin
		if (srst_in) begin
			cfg_r <= `IRL_CFG_RST;
			mac_r <= `IRL_MAC_RST;
			for (i = 0; i < 8; i = i + 1) begin
				code_wr_r[i] <= `IRL_CODE_RST;
				code_act_r[i] <= `IRL_CODE_RST;
			end
		end else if (wr) begin
			if (idx == `IRL_IDX_CFG) begin
				cfg_r <= {1'b0, wb_dat_in[6:0]};
			end
			if (idx == `IRL_IDX_MAC) begin
				mac_r <= wb_dat_in[7:0];
			end
			if (is_prio) begin
				code_wr_r[idx[2:0]] <= wb_dat_in[6:0];
			end
			if (idx == `IRL_IDX_PRIO7) begin
				// commit all staged codes together
				for (i = 0; i < 7; i = i + 1) begin
					code_act_r[i] <= code_wr_r[i];
				end
				code_act_r[7] <= wb_dat_in[6:0];
			end
		end
	end

	// read data and acknowledge
	always @(posedge clock_in) begin
		if (srst_in) begin
			ack_r <= 1'b0;
			wb_dat_out <= 32'd0;
		end else begin
			ack_r <= req;
			if (req) begin
				if (idx == `IRL_IDX_CFG) begin
					wb_dat_out <= {24'd0, cfg_r};
				end else if (idx == `IRL_IDX_MAC) begin
					wb_dat_out <= {24'd0, mac_r};
				end else if (is_prio) begin
					wb_dat_out <= {25'd0, code_wr_r[idx[2:0]]};
				end else if (idx == `IRL_IDX_STAT) begin
					wb_dat_out <= {30'd0, ovr_r, flow_ctrl_out};
				end else begin
					wb_dat_out <= 32'd0;
				end
			end
		end
	end

	assign wb_ack_out = ack_r;

endmodule // irl_limiter

//--- irl_limiter_assertions.sv
// checker on the limiter ports, bound into irl_limiter
// assumes a classic wishbone master and one frame per pulse
`timescale 1ns/1ps
module irl_chk (
	// observed ports
	input wire        clock_in,
	input wire        srst_in,
	input wire        wb_cyc_in,
	input wire        wb_stb_in,
	input wire        wb_we_in,
	input wire [9:0]  wb_adr_in,
	input wire [3:0]  wb_sel_in,
	input wire [31:0] wb_dat_in,
	input wire [31:0] wb_dat_out,
	input wire        wb_ack_out,
	input wire        frame_valid_in,
	input wire        frame_bcast_in,
	input wire        frame_mcast_in,
	input wire        frame_flood_in,
	input wire        frame_drop_out,
	input wire        flow_ctrl_out
);
	reg  [1:0] mode_r;
	reg        fc_r;
	reg        rx_r;
	wire       req = wb_cyc_in & wb_stb_in;
	wire       wr = req & wb_we_in & wb_ack_out & wb_sel_in[0];
	wire [7:0] idx = wb_adr_in[9:2];
	default clocking @(posedge clock_in); endclocking
	default disable iff (srst_in);
	// shadow of written limit mode and flow enables
	always @(posedge clock_in) begin
		if (srst_in) begin
			mode_r <= 2'h0;
			fc_r   <= 1'h0;
			rx_r   <= 1'h0;
		end else if (wr && idx == 8'h03) begin
			mode_r <= wb_dat_in[3:2];
			fc_r   <= wb_dat_in[4];
		end else if (wr && idx == 8'h20)
			rx_r <= wb_dat_in[3];
	end
	ack_next_a: assert property (req && !wb_ack_out |=> wb_ack_out)
		else $error("request not acked next cycle");
	ack_pulse_a: assert property (wb_ack_out |=> !wb_ack_out)
		else $error("ack longer than one cycle");
	rd_high_a: assert property (wb_ack_out && !wb_we_in |->
		wb_dat_out[31:8] == 24'h000000) else $error("read upper bits set");
	drop_cause_a: assert property (frame_drop_out |->
		$past(frame_valid_in)) else $error("drop without frame");
	mode_b_a: assert property (frame_drop_out && mode_r == 2'h3 |->
		$past(frame_bcast_in)) else $error("uncounted frame dropped");
	mode_bm_a: assert property (frame_drop_out && mode_r == 2'h2 |->
		$past(frame_bcast_in | frame_mcast_in)) else $error("bad drop");
	mode_bmf_a: assert property (frame_drop_out && mode_r == 2'h1 |->
		$past(frame_bcast_in | frame_mcast_in | frame_flood_in))
		else $error("unicast frame dropped");
	flow_gate_a: assert property (flow_ctrl_out |-> fc_r && rx_r)
		else $error("flow control without enables");
	rst_idle_a: assert property (disable iff (1'b0) srst_in |=>
		!wb_ack_out && !frame_drop_out && !flow_ctrl_out)
		else $error("outputs active after reset");
	cover property (frame_drop_out && flow_ctrl_out);
	cover property (wb_ack_out && !wb_we_in);
	cover property (frame_drop_out && mode_r == 2'h3);
endmodule // irl_chk

bind irl_limiter irl_chk chk_u (.*);

//--- irl_link_src.sv
// link partner model sending frame descriptors back to back
// assumes the core clock and a synchronous active-high reset
`timescale 1ns/1ps
module irl_link_src #(
	parameter W = 1000
) (
	// clock, reset and limiter verdict
	input wire        clock_in,
	input wire        srst_in,
	input wire        frame_drop_in,
	// frame descriptor
	output reg        frame_valid_out = 1'b0,
	output reg [15:0] frame_len_out = 16'h0000,
	output reg [2:0]  frame_prio_out = 3'h0,
	output reg        frame_bcast_out = 1'b0,
	output reg        frame_mcast_out = 1'b0,
	output reg        frame_flood_out = 1'b0
);
	integer    cyc_n = 0;
	reg [31:0] drops = 32'h0;
	// window phase and count of dropped frames
	always @(posedge clock_in) begin
		cyc_n <= srst_in ? 0 : cyc_n + 1;
		if (frame_drop_in)
			drops <= drops + 32'h1;
	end
	// n frames in a fresh window; idle lines show inverted data
	task burst(input integer n, input [15:0] ln, input [2:0] pr,
		input [2:0] cl);
		integer i;
		begin
			while (cyc_n % W != 10)
				@(posedge clock_in);
			drops = 32'h0;
			for (i = 0; i < n; i = i + 1) begin
				frame_valid_out <= 1'b1;
				frame_len_out <= ln;
				frame_prio_out <= pr;
				{frame_bcast_out, frame_mcast_out, frame_flood_out} <= cl;
				@(posedge clock_in);
			end
			frame_valid_out <= 1'b0;
			frame_len_out <= ~ln;
			frame_prio_out <= ~pr;
			{frame_bcast_out, frame_mcast_out, frame_flood_out} <= ~cl;
			repeat (3) @(posedge clock_in);
		end
	endtask
endmodule // irl_link_src

//--- ingress_rate_limiter_test.sv
// register and traffic tests for the ingress rate limiter
// assumes a 1000-cycle window; limits hold per window
`timescale 1ns/1ps
module ingress_rate_limiter_test;
	reg         clock_in = 1'b0;
	reg         srst_in = 1'b1;
	reg         cyc_r = 1'b0;
	reg         we_r = 1'b0;
	reg  [9:0]  adr_r = 10'h000;
	reg  [31:0] dat_r = 32'h0;
	wire [31:0] rdat;
	wire        ack;
	wire        fv, fb, fm, ff, drop, flow;
	wire [15:0] fl;
	wire [2:0]  fp;
	integer     n_errors = 0;
	integer     samples_checked = 0;
	integer     m;
	irl_limiter #(.WINDOW_CYC(1000)) dut_u (.clock_in(clock_in),
		.srst_in(srst_in), .wb_cyc_in(cyc_r), .wb_stb_in(cyc_r),
		.wb_we_in(we_r), .wb_adr_in(adr_r), .wb_sel_in(4'hF),
		.wb_dat_in(dat_r), .wb_dat_out(rdat), .wb_ack_out(ack),
		.frame_valid_in(fv), .frame_len_in(fl), .frame_prio_in(fp),
		.frame_bcast_in(fb), .frame_mcast_in(fm), .frame_flood_in(ff),
		.frame_drop_out(drop), .flow_ctrl_out(flow));
	irl_link_src #(.W(1000)) src_u (.clock_in(clock_in),
		.srst_in(srst_in), .frame_drop_in(drop), .frame_valid_out(fv),
		.frame_len_out(fl), .frame_prio_out(fp), .frame_bcast_out(fb),
		.frame_mcast_out(fm), .frame_flood_out(ff));
	// 25 MHz clock
	always #20 clock_in = ~clock_in;
	task chk(input string nm, input [31:0] e, input [31:0] g);
		begin
			samples_checked = samples_checked + 1;
			if (g !== e) begin
				n_errors = n_errors + 1;
				$display("ERROR %s expected %h seen %h", nm, e, g);
			end
		end
	endtask
	// one classic wishbone cycle, held until ack
	task bus(input w, input [7:0] ix, input [7:0] d, output [31:0] q);
		begin
			cyc_r <= 1'b1;
			we_r <= w;
			adr_r <= {ix, 2'b00};
			dat_r <= {24'h000000, d};
			@(posedge clock_in);
			while (ack !== 1'b1)
				@(posedge clock_in);
			q = rdat;
			cyc_r <= 1'b0;
			@(posedge clock_in);
		end
	endtask
	task wr(input [7:0] ix, input [7:0] d);
		reg [31:0] q;
		bus(1'b1, ix, d, q);
	endtask
	task rd(input [7:0] ix, input [31:0] e);
		reg [31:0] q;
		begin
			bus(1'b0, ix, 8'h00, q);
			chk("register", e, q);
		end
	endtask
	task run(input integer n, input [15:0] ln, input [2:0] pr,
		input [2:0] cl, input [31:0] e);
		begin
			src_u.burst(n, ln, pr, cl);
			chk("drops", e, src_u.drops);
		end
	endtask
	task final_report;
		begin
			$display("checks %0d errors %0d", samples_checked, n_errors);
			if (n_errors == 0 && samples_checked > 0)
				$display("RESULT: PASS");
			else
				$display("RESULT: FAIL");
			$finish;
		end
	endtask
	// watchdog against a hang
	initial begin
		#(80000 * 40);
		n_errors = n_errors + 1;
		final_report;
	end
	// main sequence
	initial begin
		repeat (3) @(posedge clock_in);
		srst_in <= 1'b0;
		rd(8'h03, 32'h0);
		rd(8'h20, 32'h10);
		rd(8'h30, 32'h0);
		wr(8'h03, 8'hFF);
		rd(8'h03, 32'h7F);
		wr(8'h10, 8'hFF);
		rd(8'h10, 32'h7F);
		wr(8'h10, 8'h00);
		$display("test registers done");
		wr(8'h20, 8'h08);
		wr(8'h03, 8'h20);
		wr(8'h13, 8'h65);
		run(70, 16'd64, 3'd3, 3'h0, 0);
		wr(8'h17, 8'h00);
		run(70, 16'd64, 3'd3, 3'h0, 6);
		run(70, 16'd64, 3'd2, 3'h0, 0);
		$display("test commit done");
		wr(8'h10, 8'h65);
		wr(8'h17, 8'h00);
		wr(8'h03, 8'h70);
		run(70, 16'd64, 3'd5, 3'h0, 6);
		chk("flow", 32'h1, {31'h0, flow});
		rd(8'h21, 32'h3);
		wr(8'h20, 8'h00);
		run(70, 16'd64, 3'd5, 3'h0, 6);
		chk("flow", 32'h0, {31'h0, flow});
		wr(8'h20, 8'h08);
		wr(8'h03, 8'h61);
		run(70, 16'd64, 3'd5, 3'h0, 6);
		chk("flow", 32'h0, {31'h0, flow});
		$display("test port done");
		wr(8'h03, 8'h40);
		run(10, 16'd989, 3'd0, 3'h0, 2);
		wr(8'h03, 8'h41);
		run(10, 16'd989, 3'd0, 3'h0, 2);
		wr(8'h03, 8'h42);
		run(10, 16'd989, 3'd0, 3'h0, 3);
		run(10, 16'd988, 3'd0, 3'h0, 2);
		wr(8'h03, 8'h43);
		run(10, 16'd989, 3'd0, 3'h0, 3);
		$display("test bytes done");
		for (m = 0; m < 4; m = m + 1) begin
			wr(8'h03, 8'h60 | (m[7:0] << 2));
			run(70, 16'd64, 3'd0, 3'h4, 6);
			run(70, 16'd64, 3'd0, 3'h2, (m == 3) ? 0 : 6);
			run(70, 16'd64, 3'd0, 3'h1, (m < 2) ? 6 : 0);
		end
		$display("test modes done");
		wr(8'h03, 8'h40);
		wr(8'h10, 8'h01);
		wr(8'h17, 8'h00);
		run(130, 16'd1000, 3'd0, 3'h0, 5);
		wr(8'h10, 8'h0B);
		wr(8'h17, 8'h00);
		run(20, 16'hFFFF, 3'd0, 3'h0, 1);
		wr(8'h03, 8'h60);
		wr(8'h10, 8'h66);
		wr(8'h17, 8'h00);
		run(130, 16'd64, 3'd0, 3'h0, 2);
		wr(8'h10, 8'h65);
		wr(8'h17, 8'h00);
		wr(8'h20, 8'h40);
		wr(8'h03, 8'h60);
		run(645, 16'd64, 3'd0, 3'h0, 5);
		$display("test speed done");
		final_report;
	end
endmodule // ingress_rate_limiter_test
